/* File: inc/sdrc_consts.svh */
`ifndef SDRC_CONSTS_SVH
`define SDRC_CONSTS_SVH

// =====================================================================
// Timing
// Clock period in ns at 25 MHz
`define SDRC_CLK_PERIOD_NS 40
// Least refresh cycle time in ns (plain default)
`define SDRC_TRFC_NS 300

// =====================================================================
// Address field positions
`define SDRC_BURST_SEL_BIT 12
`define SDRC_AUTO_PRE_BIT 10
`define SDRC_COL_MSB 9

// =====================================================================
// Widths and reset values
`define SDRC_ROW_W 16
`define SDRC_BANKS 8
`define SDRC_ROW_RESET 16'h0000
`define SDRC_TIMER_W 8

`endif

/* File: inc/sdrc_pkg.sv */
package sdrc_pkg;

    // Sampled command and address pins
    typedef struct packed {
        logic cke;
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
        logic [2:0] ba;
        logic [15:0] addr;
        logic wr_err;
    } sdrc_pin_s;

    // Column access handed to the array
    typedef struct packed {
        logic write;
        logic burst8;
        logic auto_pre;
        logic [2:0] bank;
        logic [9:0] col;
    } sdrc_col_s;

    // Device command state
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REFRESH,
        ST_SELF_REF
    } sdrc_state_e;

endpackage

/* File: src/sdrc_row_ctr.sv */
`timescale 1ns/100ps
`include "sdrc_consts.svh"

module sdrc_row_ctr #(
    parameter int ROW_W = `SDRC_ROW_W
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic advance,
    output logic [ROW_W-1:0] row
);

    // =================================================================
    // Internal refresh row address, steps once per refresh
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            row <= ROW_W'(`SDRC_ROW_RESET);
        end else if (advance) begin
            row <= row + ROW_W'(1);
        end
    end

endmodule

/* File: src/sdrc_top.sv */
`timescale 1ns/100ps
`include "sdrc_consts.svh"

// Overview of operation
// - Address bit 12 low picks chopped four-beat, high eight-beat burst.
// - Address bit 12 on column commands never forms part of the column.
// - Data setup or hold errors corrupt only the addressed location, no hang.
// - Strobe or strobe-to-clock errors corrupt only the addressed location.
// - Chip select, row and column strobes low, write high start refresh.
// - Refresh rows come from internal counter; external address is ignored.
// - All banks end in precharged idle state when refresh completes.
// - After self-refresh exit, one refresh is needed before re-entry.
module sdrc_top #(
    parameter int TIMER_W = `SDRC_TIMER_W,
    parameter int ROW_W = `SDRC_ROW_W,
    parameter int BANKS = `SDRC_BANKS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic [2:0] ba,
    input wire logic [15:0] addr,
    input wire logic wr_err,
    output sdrc_pkg::sdrc_col_s col_out,
    output logic col_valid,
    output logic data_suspect,
    output logic refresh_busy,
    output logic [ROW_W-1:0] refresh_row,
    output logic [BANKS-1:0] banks_open,
    output logic self_refresh,
    output logic sre_refused
);

    // =================================================================
    // Timing counts
    localparam int TRFC_CYC =
        (`SDRC_TRFC_NS + `SDRC_CLK_PERIOD_NS - 1) / `SDRC_CLK_PERIOD_NS;
    localparam logic [TIMER_W-1:0] TRFC_LOAD = TIMER_W'(TRFC_CYC - 1);

    // Command decode on sampled control pins
    function automatic logic cmd_is(input sdrc_pkg::sdrc_pin_s p,
                                    input logic [3:0] code);
        cmd_is = !p.cs_b && ({p.ras_b, p.cas_b, p.we_b} == code[2:0]);
    endfunction

    // =================================================================
    // Pin synchronisers
    sdrc_pkg::sdrc_pin_s pins_s1_reg;
    sdrc_pkg::sdrc_pin_s pins_q;
    sdrc_pkg::sdrc_pin_s pins_raw;
    logic cke_prev_reg;

    assign pins_raw = '{cke: cke, cs_b: cs_b, ras_b: ras_b, cas_b: cas_b,
                        we_b: we_b, ba: ba, addr: addr, wr_err: wr_err};

    // Two flops before any decode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pins_s1_reg <= '0;
            pins_q <= '0;
            cke_prev_reg <= 1'b0;
        end else begin
            pins_s1_reg <= pins_raw;
            pins_q <= pins_s1_reg;
            cke_prev_reg <= pins_q.cke;
        end
    end

    // =================================================================
    // Command decode
    sdrc_pkg::sdrc_state_e state_reg;
    sdrc_pkg::sdrc_state_e state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    logic need_ref_reg;
    logic need_ref_next;
    logic [ROW_W-1:0] ctr_row;

    wire live = pins_q.cke && cke_prev_reg;
    wire is_act = live && cmd_is(pins_q, 4'h3);
    wire is_pre = live && cmd_is(pins_q, 4'h2);
    wire is_rd = live && cmd_is(pins_q, 4'h5);
    wire is_wr = live && cmd_is(pins_q, 4'h4);
    wire is_ref = live && cmd_is(pins_q, 4'h1);
    wire is_sre = !pins_q.cke && cke_prev_reg && cmd_is(pins_q, 4'h1);
    wire is_srx = pins_q.cke && !cke_prev_reg;
    wire in_idle = (state_reg == sdrc_pkg::ST_IDLE);
    wire in_sref = (state_reg == sdrc_pkg::ST_SELF_REF);
    wire col_cmd = in_idle && (is_rd || is_wr);
    wire auto_pre = pins_q.addr[`SDRC_AUTO_PRE_BIT];
    wire ref_start = in_idle && is_ref;
    // entry refused until a refresh after exit
    wire sre_ok = in_idle && is_sre && !need_ref_reg;
    wire sre_bad = in_idle && is_sre && need_ref_reg;
    wire ref_done = (state_reg == sdrc_pkg::ST_REFRESH) &&
                    (timer_reg == '0);
    // Self-refresh does one internal refresh on entry
    wire row_step = ref_start || sre_ok;

    // rows only from the internal counter
    sdrc_row_ctr #(
        .ROW_W(ROW_W)
    ) u_row_ctr (
        .clock(clock),
        .rst_b(rst_b),
        .advance(row_step),
        .row(ctr_row)
    );

    // =================================================================
    // Column request build
    sdrc_pkg::sdrc_col_s col_next;
    // column field stops below the selector bit
    assign col_next = '{write: is_wr,
                        burst8: pins_q.addr[`SDRC_BURST_SEL_BIT],
                        auto_pre: auto_pre,
                        bank: pins_q.ba,
                        col: pins_q.addr[`SDRC_COL_MSB:0]};

    // =================================================================
    // Bank tracking
    logic [BANKS-1:0] bank_hot;
    logic [BANKS-1:0] banks_next;
    assign bank_hot = BANKS'(1) << pins_q.ba;

    always_comb begin
        banks_next = banks_open;
        if (ref_done) begin
            banks_next = '0;
        end else if (in_idle && is_act) begin
            banks_next = banks_open | bank_hot;
        end else if (in_idle && is_pre) begin
            banks_next = auto_pre ? '0 : (banks_open & ~bank_hot);
        end else if (col_cmd && auto_pre) begin
            banks_next = banks_open & ~bank_hot;
        end
    end

    // =================================================================
    // Command state machine
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        need_ref_next = need_ref_reg;
        case (state_reg)
            sdrc_pkg::ST_IDLE: begin
                if (ref_start) begin
                    state_next = sdrc_pkg::ST_REFRESH;
                    timer_next = TRFC_LOAD;
                end else if (sre_ok) begin
                    state_next = sdrc_pkg::ST_SELF_REF;
                end
            end
            sdrc_pkg::ST_REFRESH: begin
                // Commands here ignored; address bus unused
                if (timer_reg == '0) begin
                    state_next = sdrc_pkg::ST_IDLE;
                    need_ref_next = 1'b0;
                end else begin
                    timer_next = timer_reg - TIMER_W'(1);
                end
            end
            sdrc_pkg::ST_SELF_REF: begin
                if (is_srx) begin
                    state_next = sdrc_pkg::ST_IDLE;
                    need_ref_next = 1'b1;
                end
            end
            default: begin
                state_next = sdrc_pkg::ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= sdrc_pkg::ST_IDLE;
            timer_reg <= '0;
            need_ref_reg <= 1'b0;
            banks_open <= '0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            need_ref_reg <= need_ref_next;
            banks_open <= banks_next;
        end
    end

    // =================================================================
    // Registered outputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            col_out <= '0;
            col_valid <= 1'b0;
            data_suspect <= 1'b0;
            refresh_busy <= 1'b0;
            refresh_row <= ROW_W'(`SDRC_ROW_RESET);
            self_refresh <= 1'b0;
            sre_refused <= 1'b0;
        end else begin
            col_valid <= col_cmd;
            if (col_cmd) begin
                col_out <= col_next;
            end
            // bad write data marks only that location
            // strobe errors never stall the decoder
            data_suspect <= col_cmd && is_wr && pins_q.wr_err;
            refresh_busy <= (state_next == sdrc_pkg::ST_REFRESH);
            if (row_step) begin
                refresh_row <= ctr_row;
            end
            self_refresh <= (state_next == sdrc_pkg::ST_SELF_REF);
            sre_refused <= sre_bad;
        end
    end

    // =================================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    AST_BURST_SEL: assert property (col_cmd |=> col_valid &&
        col_out.burst8 == $past(pins_q.addr[12]))
        else $error("Burst length does not follow selector bit");

    AST_COL_NO_SEL: assert property (col_cmd |=>
        col_out.col == $past(pins_q.addr[9:0]))
        else $error("Column address not taken from low bits");

    // write error flagged, next command still served
    AST_WERR_FLAG: assert property ((col_cmd && is_wr && pins_q.wr_err)
        |=> data_suspect && state_reg == sdrc_pkg::ST_IDLE)
        else $error("Write data error not confined to the access");

    // strobe errors never move the state machine
    AST_WERR_STATE: assert property ((in_idle && pins_q.wr_err &&
        !is_ref && !is_sre) |=> in_idle)
        else $error("Write error changed device state");

    AST_REF_START: assert property (ref_start |=>
        refresh_busy && state_reg == sdrc_pkg::ST_REFRESH)
        else $error("Refresh command did not start a refresh");

    // refresh row stands for the whole cycle
    AST_REF_ROW: assert property ((refresh_busy && $past(refresh_busy))
        |-> $stable(refresh_row))
        else $error("Refresh row changed during refresh");

    AST_REF_DONE: assert property ($fell(refresh_busy) && !self_refresh
        |-> banks_open == '0)
        else $error("Banks left open after refresh");

    AST_SRE_GATE: assert property (sre_bad |=>
        sre_refused && !self_refresh ##1 in_idle)
        else $error("Self-refresh re-entry accepted without refresh");

endmodule

/* File: tb/sdrc_ctl_model.sv */
`timescale 1ns/100ps

// =====================================
// Controller side of the command bus
module sdrc_ctl_model #(
    parameter int TRFC_CYC = 8,
    parameter int TRP_CYC = 3,
    parameter int TREFI_CYC = 400
) (
    input wire logic clock,
    output sdrc_pkg::sdrc_pin_s pins
);
    int owed = 0;
    int n_ref = 0;

    // Bus at rest, clock enable low
    initial begin
        pins = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 3'h0, 16'h0000, 1'h0};
    end

    always begin
        repeat (TREFI_CYC) @(posedge clock);
        owed = owed + 1;
    end

    // One command, then a released bus
    task automatic issue(input logic [3:0] cmd, input logic [2:0] b,
        input logic [15:0] a, input logic e, input logic k);
        if (cmd[3:1] == 3'h2) begin
            repeat (2) @(posedge clock);
        end
        @(posedge clock);
        #1;
        pins = '{k, cmd[3], cmd[2], cmd[1], cmd[0], b, a, e};
        @(posedge clock);
        #1;
        pins = '{k, 1'h1, 1'h1, 1'h1, 1'h1, ~b, ~a, 1'h0};
    endtask

    task automatic refresh(input logic [15:0] a);
        issue(4'h2, 3'h0, 16'h0400, 1'h0, 1'h1);
        repeat (TRP_CYC) @(posedge clock);
        issue(4'h1, 3'h0, a, 1'h0, 1'h1);
        n_ref = n_ref + 1;
        owed = (owed > -8) ? owed - 1 : owed;
        repeat (TRFC_CYC + 2) @(posedge clock);
    endtask

    task automatic settle;
        while (owed > 0) begin
            refresh(16'($urandom));
        end
    endtask

    task automatic sre;
        settle;
        issue(4'h1, 3'h0, 16'($urandom), 1'h0, 1'h0);
        n_ref = n_ref + 1;
    endtask
endmodule

/* File: tb/test_sdram_refresh_burst_chop.sv */
`timescale 1ns/100ps

module test_sdram_refresh_burst_chop;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    sdrc_pkg::sdrc_pin_s pins;
    sdrc_pkg::sdrc_col_s col_out;
    logic col_valid, data_suspect, refresh_busy, self_refresh, sre_refused;
    logic [15:0] refresh_row;
    logic [7:0] banks_open;
    logic [7:0] exp_open;
    logic [15:0] busy_cycles = 16'h0000;
    logic [15:0] a;
    logic [2:0] b;
    logic e, w;
    int fail_count = 0;
    int n_compared = 0;
    int seed;

    // =====================================
    // Clock, controller and device
    initial begin
        forever #20 clock = ~clock;
    end

    sdrc_ctl_model ctl (.clock(clock), .pins(pins));

    sdrc_top dut (
        .clock(clock), .rst_b(rst_b), .cke(pins.cke), .cs_b(pins.cs_b),
        .ras_b(pins.ras_b), .cas_b(pins.cas_b), .we_b(pins.we_b),
        .ba(pins.ba), .addr(pins.addr), .wr_err(pins.wr_err),
        .col_out(col_out), .col_valid(col_valid),
        .data_suspect(data_suspect), .refresh_busy(refresh_busy),
        .refresh_row(refresh_row), .banks_open(banks_open),
        .self_refresh(self_refresh), .sre_refused(sre_refused)
    );

    // Busy cycle count
    always @(posedge clock) begin
        if (refresh_busy === 1'h1) busy_cycles += 16'h0001;
    end

    // =====================================
    // Checks and verdict
    task automatic await_answer;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // Expected column request from the command fields
    function automatic sdrc_pkg::sdrc_col_s exp_col(input logic wr,
        input logic [15:0] ad, input logic [2:0] bk);
        exp_col = sdrc_pkg::sdrc_col_s'{wr, ad[12], ad[10], bk, ad[9:0]};
    endfunction

    task automatic chk_col(input sdrc_pkg::sdrc_col_s got,
        input sdrc_pkg::sdrc_col_s exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: column %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(40 * 20000);
        fail_count++;
        conclude;
    end

    // =====================================
    // Main sequence
    initial begin
        seed = $urandom(49);
        repeat (4) @(posedge clock);
        #1;
        chk_flag(refresh_busy, 1'h0);
        chk_word({8'h00, banks_open}, 16'h0000);
        rst_b = 1'h1;
        ctl.issue(4'hf, 3'h0, 16'h0000, 1'h0, 1'h1);
        exp_open = 8'h00;
        // Column traffic, both burst kinds, corner columns first
        for (int i = 0; i < 24; i++) begin
            if (ctl.owed > 0) exp_open = 8'h00;
            ctl.settle;
            b = 3'($urandom);
            a = (i < 2) ? (16'h0bff | 16'(i << 12)) : 16'($urandom);
            e = 1'($urandom);
            w = 1'($urandom);
            ctl.issue(4'h3, b, 16'($urandom), 1'h0, 1'h1);
            exp_open[b] = 1'h1;
            ctl.issue(w ? 4'h4 : 4'h5, b, a, e, 1'h1);
            if (a[10]) exp_open[b] = 1'h0;
            await_answer;
            chk_col(col_out, exp_col(w, a, b));
            chk_flag(col_valid, 1'h1);
            chk_flag(data_suspect, w & e);
            chk_word({8'h00, banks_open}, {8'h00, exp_open});
            @(posedge clock);
            #1;
            chk_flag(col_valid, 1'h0);
            // Single-bank precharge now and then
            if (i % 3 == 0) begin
                ctl.issue(4'h2, b, 16'($urandom) & 16'hfbff, 1'h0, 1'h1);
                exp_open[b] = 1'h0;
                await_answer;
                chk_word({8'h00, banks_open}, {8'h00, exp_open});
            end
        end
        // Refresh with a random, ignored address
        for (int i = 0; i < 2; i++) begin
            busy_cycles = 16'h0000;
            ctl.refresh(16'($urandom));
            await_answer;
            chk_word(busy_cycles, 16'h0008);
            chk_word(refresh_row, 16'(ctl.n_ref - 1));
            chk_word({8'h00, banks_open}, 16'h0000);
        end
        // Self-refresh, exit, refused and granted re-entry
        ctl.sre;
        await_answer;
        chk_flag(self_refresh, 1'h1);
        chk_word(refresh_row, 16'(ctl.n_ref - 1));
        ctl.issue(4'hf, 3'h0, 16'h0000, 1'h0, 1'h1);
        await_answer;
        chk_flag(self_refresh, 1'h0);
        ctl.issue(4'h1, 3'h0, 16'h0000, 1'h0, 1'h0);
        await_answer;
        chk_flag(sre_refused, 1'h1);
        chk_flag(self_refresh, 1'h0);
        ctl.issue(4'hf, 3'h0, 16'h0000, 1'h0, 1'h1);
        ctl.refresh(16'hffff);
        ctl.sre;
        await_answer;
        chk_flag(self_refresh, 1'h1);
        conclude;
    end
endmodule
